// *** rtl/pbsp_port.sv ***
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - clock qualifier high freezes burst state, pipeline stages and burst counter for that edge; sleep sequencer still runs
// - qualified edge, all selects active, write strobe high, load low starts read
// - read data driven from the edge after the address edge when enabled
// - new operation accepted every cycle, no idle between accesses
// - deselect tri-states the data outputs after the next edge
// - one loaded address serves four addresses by burst counter, which wraps back to the start on further advances
// - order strap low linear, high interleaved
// - burst counter steps only the two low address bits, wrapping
// - advance high steps counter of an open burst, ignores selects and write strobe
// - write strobe captured at burst start, held for all beats
// - qualified edge, all selects active, write strobe low starts write
// - edge after write address tri-states outputs regardless of enable
// - write data latched at the second edge after the address edge
// - only byte lanes with active select are written
// - sleep request enters retentive low power, two cycles to enter and exit
// - accesses pending at sleep entry are dropped
// - interleaved burst address is start xor beat index
// - linear burst address counts up modulo four from start
// - output enable ignored first cycle out of deselect, in writes, deselected
// - powers up deselected with data lines tri-stated
module pbsp_port
  import pbsp_pkg::*;
#(
  parameter int DEPTH = 1 << ADDR_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // bus control
  input wire logic clock_qualify_n,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic advance_or_load,
  input wire logic write_strobe_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [LANES-1:0] byte_lane_select_n,
  input wire logic out_drive_n,
  input wire logic burst_order,
  input wire logic sleep_request,
  // data and parity lanes, parity is the top bit of each lane
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // status
  output logic asleep
);

  logic [DATA_W-1:0] mem [DEPTH];

  // two-stage synchronisers for pins from outside the clock domain
  // output enable: only stage two feeds logic
  logic oe_s1_r;
  logic oe_s2_r;
  always_ff @(posedge mclk) begin
    oe_s1_r <= out_drive_n;
    oe_s2_r <= oe_s1_r;
  end

  // sleep request: same two-stage treatment
  logic zz_s1_r;
  logic zz_s2_r;
  always_ff @(posedge mclk) begin
    zz_s1_r <= sleep_request;
    zz_s2_r <= zz_s1_r;
  end

  // sleep sequencer
  pbsp_sleep_t sleep_r, sleep_nxt;
  logic [1:0] slp_cnt_r, slp_cnt_nxt;
  wire awake = (sleep_r == PBSP_AWAKE) && (slp_cnt_r == SLEEP_CNT_ZERO);
  always_comb begin
    sleep_nxt = sleep_r;
    slp_cnt_nxt = slp_cnt_r;
    unique case (sleep_r)
      PBSP_AWAKE: begin
        if (zz_s2_r) begin
          sleep_nxt = PBSP_ENTER;
          slp_cnt_nxt = 2'(SLEEP_CYC - 1);
        end else if (slp_cnt_r != SLEEP_CNT_ZERO) begin
          slp_cnt_nxt = slp_cnt_r - 2'h1;
        end
      end
      PBSP_ENTER: begin
        if (!zz_s2_r) begin
          sleep_nxt = PBSP_AWAKE;
          slp_cnt_nxt = 2'(SLEEP_CYC);
        end else if (slp_cnt_r == SLEEP_CNT_ZERO) begin
          sleep_nxt = PBSP_ASLEEP;
        end else begin
          slp_cnt_nxt = slp_cnt_r - 2'h1;
        end
      end
      PBSP_ASLEEP: begin
        if (!zz_s2_r) begin
          sleep_nxt = PBSP_AWAKE;
          slp_cnt_nxt = 2'(SLEEP_CYC);
        end
      end
      default: sleep_nxt = PBSP_AWAKE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sleep_r <= PBSP_AWAKE;
      slp_cnt_r <= SLEEP_CNT_ZERO;
    end else begin
      sleep_r <= sleep_nxt;
      slp_cnt_r <= slp_cnt_nxt;
    end
  end
  assign asleep = (sleep_r == PBSP_ASLEEP);

  // command decode
  wire qual_edge = !clock_qualify_n;
  wire step = awake && qual_edge;
  wire sel_a = !chip_select_a_n;
  wire sel_b = chip_select_b;
  wire sel_c = !chip_select_c_n;
  wire selected = sel_a && sel_b && sel_c;
  wire load_cyc = !advance_or_load;
  wire load_rd = selected && load_cyc && write_strobe_n;
  wire load_wr = selected && load_cyc && !write_strobe_n;
  wire desel = !selected && load_cyc;

  // burst state: base address, start bits, beat index, access type
  logic [ADDR_W-1:0] base_r;
  logic [BURST_W-1:0] beat_r;
  logic burst_wr_r, burst_act_r;
  wire [BURST_W-1:0] beat_nxt = beat_r + BURST_ONE;
  wire [BURST_W-1:0] start_bits = base_r[BURST_W-1:0];
  wire [BURST_W-1:0] lin_bits = start_bits + beat_nxt;
  wire [BURST_W-1:0] ilv_bits = start_bits ^ beat_nxt;
  wire [BURST_W-1:0] adv_bits = burst_order ? ilv_bits : lin_bits;
  wire [ADDR_W-1:0] adv_addr = {base_r[ADDR_W-1:BURST_W], adv_bits};

  // stage 0: operation accepted at this edge
  wire take_load = load_rd || load_wr;
  // an advance with no open burst only continues a deselect
  wire take_adv = advance_or_load && burst_act_r;
  pbsp_op_t op_now;
  always_comb begin
    op_now = '0;
    if (take_load) begin
      op_now.valid = 1'b1;
      op_now.write = load_wr;
      op_now.addr = addr;
    end else if (take_adv) begin
      op_now.valid = 1'b1;
      op_now.write = burst_wr_r;
      op_now.addr = adv_addr;
    end
  end

  // burst address: base and beat index move only on qualified edges
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      base_r <= '0;
      beat_r <= '0;
    end else if (step) begin
      if (take_load) begin
        base_r <= addr;
        beat_r <= '0;
      end else if (take_adv) begin
        beat_r <= beat_nxt;
      end
    end
  end

  // burst type and open flag; sleep closes any open burst
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      burst_wr_r <= 1'b0;
      burst_act_r <= 1'b0;
    end else if (!awake) begin
      burst_act_r <= 1'b0;
    end else if (step) begin
      if (take_load) begin
        burst_wr_r <= load_wr;
        burst_act_r <= 1'b1;
      end else if (desel) begin
        burst_act_r <= 1'b0;
      end
    end
  end

  // pipeline: stage 1 holds the access latched at the last qualified edge
  pbsp_op_t st1_r;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st1_r <= '0;
    end else if (!awake) begin
      st1_r <= '0;
    end else if (step) begin
      st1_r <= op_now;
    end
  end

  // stage 2 is the write data phase, one edge further on
  pbsp_op_t st2_r;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st2_r <= '0;
    end else if (!awake) begin
      st2_r <= '0;
    end else if (step) begin
      st2_r <= st1_r;
    end
  end

  // write phase: a stage 2 write takes the bus data at this edge
  wire wr_commit = step && st2_r.valid && st2_r.write;
  wire [ADDR_W-1:0] wr_addr = st2_r.addr;
  wire [DATA_W-1:0] wr_data = data_in;
  // lane selects belong to the data beat, not to the address beat
  wire [LANES-1:0] lane_en = ~byte_lane_select_n;
  wire [LANES-1:0] lane_wr = wr_commit ? lane_en : '0;

  // read phase: a stage 1 read passes the output register at this edge
  wire rd_issue = st1_r.valid && !st1_r.write;
  wire [ADDR_W-1:0] rd_addr = st1_r.addr;
  wire [DATA_W-1:0] core_word = mem[rd_addr];
  // a read right behind a write to the same word meets it at this edge
  wire rd_hit = rd_issue && wr_commit && (wr_addr == rd_addr);

  // per lane: bypass the landing write so the read never sees a stale byte
  wire [DATA_W-1:0] rd_word;
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    wire [LANE_W-1:0] lane_in = wr_data[i*LANE_W +: LANE_W];
    wire [LANE_W-1:0] lane_core = core_word[i*LANE_W +: LANE_W];
    wire lane_bypass = rd_hit && lane_wr[i];
    assign rd_word[i*LANE_W +: LANE_W] = lane_bypass ? lane_in : lane_core;
  end

  // memory has no reset; contents kept across sleep
  always_ff @(posedge mclk) begin
    for (int i = 0; i < LANES; i++) begin
      if (lane_wr[i]) begin
        mem[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
      end
    end
  end

  // next read word: held over edges that carry no read
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] rd_data_nxt;
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (step && rd_issue) begin
      rd_data_nxt = rd_word;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // deselect, write and empty stages all leave the drive flag low
  logic rd_drive_r;
  logic rd_drive_nxt;
  always_comb begin
    rd_drive_nxt = rd_drive_r;
    if (!awake) begin
      rd_drive_nxt = 1'b0;
    end else if (step) begin
      rd_drive_nxt = rd_issue;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rd_drive_r <= 1'b0;
    end else begin
      rd_drive_r <= rd_drive_nxt;
    end
  end

  // enable pin only gates a drive that the pipeline already allows
  wire oe_pin_ok = !oe_s2_r;
  assign data_out = rd_data_r;
  assign data_oe = rd_drive_r && oe_pin_ok;

endmodule
`default_nettype wire

// *** rtl/pbsp_pkg.sv ***
package pbsp_pkg;
  localparam int ADDR_W = 12;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int BURST_W = 2;
  localparam int SLEEP_CYC = 2;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
  localparam logic [1:0] SLEEP_CNT_ZERO = 2'h0;

  // operation carried through the pipeline
  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
  } pbsp_op_t;

  typedef enum logic [2:0] {
    PBSP_AWAKE = 3'h1,
    PBSP_ENTER = 3'h2,
    PBSP_ASLEEP = 3'h4
  } pbsp_sleep_t;
endpackage

// *** testbench/pbsp_port_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module pbsp_port_assertions
  import pbsp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // bus control
  input wire logic clock_qualify_n,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic advance_or_load,
  input wire logic write_strobe_n,
  input wire logic out_drive_n,
  input wire logic sleep_request,
  // outputs
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic asleep
);
  wire q = !clock_qualify_n;
  wire sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  wire ld = q && !advance_or_load;
  wire rd = ld && sel && write_strobe_n;
  wire wr = ld && sel && !write_strobe_n;
  wire ds = ld && !sel;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  AST_STALL: assert property (clock_qualify_n |=> $stable(data_out) && $stable(data_oe))
    else $error("outputs moved on an ignored edge");
  AST_WR_TRI: assert property (wr ##1 q |=> !data_oe) else $error("driving after write");
  AST_DESEL: assert property (ds ##1 q |=> !data_oe) else $error("driving after deselect");
  AST_FIRST: assert property (ds ##1 rd |=> !data_oe) else $error("first cycle unmasked");
  AST_OE_OFF: assert property ((out_drive_n && q)[*5] |-> !data_oe)
    else $error("driving with enable high");
  AST_SLP_TRI: assert property (asleep |-> !data_oe) else $error("driving while asleep");
  AST_SLP_IN: assert property ((sleep_request && q)[*6] |-> asleep) else $error("no sleep");
  AST_SLP_OUT: assert property ((!sleep_request && q)[*6] |-> !asleep) else $error("no wake");
  AST_RST: assert property (disable iff (1'b0) !rstn |=> !data_oe && !asleep)
    else $error("not idle after reset");
endmodule
bind pbsp_port pbsp_port_assertions chk (.*);
`default_nettype wire

// *** testbench/pbsp_bus_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module pbsp_bus_model
  import pbsp_pkg::*;
(
  input wire logic mclk,
  input wire logic [DATA_W-1:0] ctl_data,
  input wire logic ctl_drive,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  output logic [DATA_W-1:0] bus,
  output logic clash
);
  logic [DATA_W-1:0] last_r = '0;
  // floating bus toggles so a stale value never looks valid
  assign bus = ctl_drive ? ctl_data : (data_oe ? data_out : ~last_r);
  assign clash = ctl_drive && data_oe;
  always_ff @(posedge mclk) begin
    last_r <= bus;
  end
endmodule
`default_nettype wire

// *** testbench/pipelined_burst_sram_port_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module pipelined_burst_sram_port_tb;
  import pbsp_pkg::*;
  logic mclk = 0, rstn = 0, clock_qualify_n = 0, chip_select_a_n = 1, chip_select_b = 0;
  logic chip_select_c_n = 1, advance_or_load = 0, write_strobe_n = 1, out_drive_n = 0;
  logic burst_order = 0, sleep_request = 0, ctl_drive = 0, data_oe, asleep, clash;
  logic wr = 0, prd = 0, prd2 = 0, w1 = 0, w2 = 0;
  logic [ADDR_W-1:0] addr = '0, base;
  logic [LANES-1:0] byte_lane_select_n = 4'hF, b1 = 4'hF, b2 = 4'hF;
  logic [DATA_W-1:0] ctl_data = '0, d1 = '0, d2 = '0, data_in, data_out, pexp, pexp2;
  logic [DATA_W-1:0] mem [int];
  logic [1:0] beat;
  int num_errors = 0, checks = 0, vis = 0;
  pbsp_port uut (.*);
  pbsp_bus_model far (.mclk(mclk), .ctl_data(ctl_data), .ctl_drive(ctl_drive),
    .data_out(data_out), .data_oe(data_oe), .bus(data_in), .clash(clash));
  initial begin
    forever #10 mclk = ~mclk;
  end
  task automatic check(input string n, input logic [DATA_W-1:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // k: 0 deselect, 1 load read, 2 load write, 3 advance
  task automatic op(input int k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    input logic [LANES-1:0] be);
    logic [ADDR_W-1:0] ea;
    @(posedge mclk);
    #1;
    check("clash", clash, 0);
    // read data shows one edge after its address edge
    if (prd2 && data_oe === 1'b1) begin
      check("read", data_out, pexp2);
      vis++;
    end
    prd2 = prd;
    pexp2 = pexp;
    if (k == 1 || k == 2) begin
      base = a;
      beat = 0;
      wr = k == 2;
    end else if (k == 3) begin
      beat++;
    end
    ea = {base[ADDR_W-1:2], burst_order ? base[1:0] ^ beat : base[1:0] + beat};
    prd = k != 0 && !wr;
    if (prd) pexp = mem[ea];
    for (int i = 0; i < LANES; i++) begin
      if (k != 0 && wr && !be[i]) mem[ea][LANE_W*i+:LANE_W] = d[LANE_W*i+:LANE_W];
    end
    clock_qualify_n <= 0;
    chip_select_a_n <= !(k == 1 || k == 2);
    chip_select_b <= k == 1 || k == 2;
    chip_select_c_n <= !(k == 1 || k == 2);
    advance_or_load <= k == 3;
    write_strobe_n <= (k == 3) ? wr : k != 2;
    addr <= a;
    ctl_data <= d2;
    ctl_drive <= w2;
    byte_lane_select_n <= b2;
    d2 = d1;
    b2 = b1;
    w2 = w1;
    d1 = d;
    b1 = be;
    w1 = k != 0 && wr;
  endtask
  task automatic rd(input int k, input int n, input logic [ADDR_W-1:0] a);
    repeat (n) op(k, a, '0, 4'hF);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1;
    #1;
    check("oe", data_oe, 0);
    check("asleep", asleep, 0);
    for (int i = 0; i < 4; i++) begin
      op(i ? 3 : 2, 12'h012, 36'h9_1357_9BD0 ^ DATA_W'(i), 4'h0);
    end
    rd(0, 2, 12'h000);
    op(2, 12'h011, 36'hF_FFFF_FFFF, 4'hA);
    rd(0, 2, 12'h000);
    burst_order <= 1;
    rd(1, 1, 12'h010);
    rd(1, 1, 12'h011);
    check("mask", data_oe, 0);
    rd(3, 1, 12'h000);
    @(posedge mclk);
    #1;
    clock_qualify_n <= 1;
    rd(3, 2, 12'h000);
    rd(0, 2, 12'h000);
    check("visible", DATA_W'(vis), 36'h5);
    out_drive_n <= 1;
    rd(0, 3, 12'h000);
    rd(1, 2, 12'h012);
    rd(0, 2, 12'h000);
    check("enable", DATA_W'(vis), 36'h5);
    out_drive_n <= 0;
    sleep_request <= 1;
    rd(0, 8, 12'h000);
    check("sleep", asleep, 1);
    sleep_request <= 0;
    rd(0, 8, 12'h000);
    check("wake", asleep, 0);
    rd(1, 1, 12'h011);
    rd(1, 1, 12'h010);
    rd(0, 2, 12'h000);
    check("retain", DATA_W'(vis), 36'h7);
    test_done;
  end
  initial begin
    repeat (500) @(posedge mclk);
    num_errors++;
    test_done;
  end
endmodule
`default_nettype wire
